// [stsi_device.sv]
// device end: serial audio input stage and biphase clock divider of the transmitter
`timescale 1ns/1ps
module stsi_device (
	input wire logic clock_i,
	input wire logic arst_n_i,
	stsi_if.device link,
	input wire logic [1:0] format_i,
	input wire logic [1:0] width_i,
	input wire logic ratio_256_i,
	input wire logic oversampling_clock_i,
	output logic [23:0] word_o,
	output logic word_left_o,
	output logic word_valid_o,
	output logic biphase_tick_o,
	output logic biphase_clk_o
);

	// =====================================================================
	// link sampling state
	// =====================================================================
	logic sclk_q, next_sclk_q;
	logic sclk_prev, next_sclk_prev;
	logic lr_q, next_lr_q;
	logic data_q, next_data_q;
	logic lr_prev, next_lr_prev; // select level at the last rising serial clock
	logic sclk_rise; // one-cycle strobe per rising serial clock

	// =====================================================================
	// slot tracking and capture state
	// =====================================================================
	// the slot position saturates at the frame end if the select stops toggling
	logic synced, next_synced;
	logic [5:0] bit_cnt, next_bit_cnt;
	logic chan_left, next_chan_left;
	logic [23:0] shift, next_shift;
	logic [23:0] next_word;
	logic next_word_left;
	logic next_word_valid;

	// =====================================================================
	// oversampling divider state
	// =====================================================================
	logic osc_q, next_osc_q;
	logic osc_prev, next_osc_prev;
	logic [1:0] div_cnt, next_div_cnt;
	logic osc_rise; // one-cycle strobe per rising oversampling clock
	logic next_biphase_tick;
	logic next_biphase_clk;

	// =====================================================================
	// framing decode
	// =====================================================================
	stsi_pkg::stsi_format_e fmt;
	stsi_pkg::stsi_width_e wid;
	logic [5:0] start;
	logic [5:0] stop;

	// format and width are meant to be static; a change mid slot spoils that slot
	// an unset format input decodes as i2s
	assign fmt = stsi_pkg::stsi_format_e'(format_i);
	assign wid = stsi_pkg::stsi_width_e'(width_i);
	// first and last slot position holding sample bits
	assign start = stsi_pkg::msb_pos(fmt, wid);
	assign stop = start + stsi_pkg::width_bits(wid) - 6'h01;

	// =====================================================================
	// link sampling and edge strobes
	// =====================================================================
	// one register stage on every wire, a second on the clock to find its edges
	always_comb begin
		next_sclk_q = link.sclk;
		next_sclk_prev = sclk_q;
		next_lr_q = link.lrclk;
		next_data_q = link.sdata;
	end

	// select and data share the clock's stage so they stay aligned to its edge
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_q <= 1'b0;
			sclk_prev <= 1'b0;
			lr_q <= 1'b0;
			data_q <= 1'b0;
		end else begin
			sclk_q <= next_sclk_q;
			sclk_prev <= next_sclk_prev;
			lr_q <= next_lr_q;
			data_q <= next_data_q;
		end
	end

	// both clocks are plain inputs, so an edge is a pair of sampled levels
	assign sclk_rise = sclk_q && !sclk_prev;
	assign osc_rise = osc_q && !osc_prev;

	// =====================================================================
	// receiver
	// =====================================================================
	// one bit is taken on each rising serial clock; a select change restarts the slot
	always_comb begin
		logic [5:0] cur;
		logic [5:0] idx;
		logic [23:0] sh;
		cur = bit_cnt;
		idx = '0;
		sh = shift;
		next_lr_prev = lr_prev;
		next_synced = synced;
		next_bit_cnt = bit_cnt;
		next_chan_left = chan_left;
		next_shift = shift;
		next_word = word_o;
		next_word_left = word_left_o;
		next_word_valid = 1'b0;
		if (sclk_rise) begin
			next_lr_prev = lr_q;
			// realigning at every select change copes with a source that drops a clock
			if (lr_q != lr_prev) begin
				// transition: this bit is slot position zero
				cur = '0;
				sh = '0;
				next_synced = 1'b1;
				next_chan_left = (lr_q == stsi_pkg::left_level(fmt));
			end else if (bit_cnt != stsi_pkg::FRAME_LAST) begin
				cur = bit_cnt + 6'h01; // saturates if the select stops toggling
			end
			next_bit_cnt = cur;
			// bits outside the sample window are dropped; the slot start cleared them
			if (cur >= start && cur <= stop) begin
				idx = cur - start;
				sh[stsi_pkg::WORD_MSB - idx[4:0]] = data_q; // msb aligned capture
			end
			next_shift = sh;
			// the lsb just arrived: hand the word on with its channel
			// the tag is the channel decoded from the select level latched at the slot start
			if (cur == stop && next_synced) begin
				next_word = sh;
				next_word_left = next_chan_left;
				next_word_valid = 1'b1;
			end
		end
	end

	// reset parks the counter at its ceiling so no word leaves before a select change
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lr_prev <= 1'b0;
			synced <= 1'b0;
			bit_cnt <= stsi_pkg::FRAME_LAST;
			chan_left <= 1'b0;
			shift <= '0;
			word_o <= '0;
			word_left_o <= 1'b0;
			word_valid_o <= 1'b0;
		end else begin
			lr_prev <= next_lr_prev;
			synced <= next_synced;
			bit_cnt <= next_bit_cnt;
			chan_left <= next_chan_left;
			shift <= next_shift;
			word_o <= next_word;
			word_left_o <= next_word_left;
			word_valid_o <= next_word_valid;
		end
	end

	// =====================================================================
	// biphase clock divider
	// =====================================================================
	// counts rising oversampling edges; 384x divides by three, 256x by two
	always_comb begin
		logic [1:0] div_last;
		div_last = (ratio_256_i ? stsi_pkg::DIV_LOW : stsi_pkg::DIV_HIGH) - 2'h1;
		next_osc_q = oversampling_clock_i;
		next_osc_prev = osc_q;
		next_div_cnt = div_cnt;
		next_biphase_tick = 1'b0;
		next_biphase_clk = biphase_clk_o;
		if (osc_rise) begin
			// >= ends the cell at once when the ratio shrinks mid count
			if (div_cnt >= div_last) begin
				next_div_cnt = '0;
				next_biphase_tick = 1'b1;
				next_biphase_clk = ~biphase_clk_o;
			end else begin
				next_div_cnt = div_cnt + 2'h1;
			end
		end
	end

	// the biphase clock starts low out of reset
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_q <= 1'b0;
			osc_prev <= 1'b0;
			div_cnt <= '0;
			biphase_tick_o <= 1'b0;
			biphase_clk_o <= 1'b0;
		end else begin
			osc_q <= next_osc_q;
			osc_prev <= next_osc_prev;
			div_cnt <= next_div_cnt;
			biphase_tick_o <= next_biphase_tick;
			biphase_clk_o <= next_biphase_clk;
		end
	end

endmodule // stsi_device

// [stsi_pkg.sv]
// constants, types and helper functions shared by both ends of the serial audio input link
// Function
// - three framings, widths 16, 18, 20 or 24
// - data and channel select taken on rising clock
// - right-justified: select high left, low right
// - right-justified msb delay 16, 14, 12, 8
// - 64 clocks per frame, lsb ends slot
// - i2s: select low left, high right
// - i2s msb one clock after transition
// - i2s is the default input format
// - left-justified: select high left, low right
// - left-justified msb at transition, no delay
// - oversampling clock divided into biphase clock
// - oversampling ratio 384 or 256 sets divider
package stsi_pkg;

	// =====================================================================
	// framing and width encodings
	// =====================================================================
	typedef enum logic [1:0] {
		STSI_FMT_I2S = 2'h0, // zero so that an unset selection means i2s
		STSI_FMT_LJ = 2'h1,
		STSI_FMT_RJ = 2'h3
	} stsi_format_e;

	typedef enum logic [1:0] {
		STSI_W16 = 2'h0,
		STSI_W18 = 2'h1,
		STSI_W20 = 2'h2,
		STSI_W24 = 2'h3
	} stsi_width_e;

	// =====================================================================
	// frame geometry
	// =====================================================================
	localparam int WORD_BITS = 24; // widest sample, msb aligned in the word
	localparam logic [4:0] WORD_MSB = 5'h17;
	localparam logic [5:0] SLOT_CLOCKS = 6'h20; // serial clocks per channel slot
	localparam logic [5:0] FRAME_LAST = 6'h3f; // 64 serial clocks per frame
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_18 = 6'h12;
	localparam logic [5:0] BITS_20 = 6'h14;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] I2S_DELAY = 6'h01;
	localparam logic [5:0] LJ_DELAY = 6'h00;
	localparam logic [5:0] RJ_DELAY_16 = 6'h10;
	localparam logic [5:0] RJ_DELAY_18 = 6'h0e;
	localparam logic [5:0] RJ_DELAY_20 = 6'h0c;
	localparam logic [5:0] RJ_DELAY_24 = 6'h08;

	// =====================================================================
	// oversampling clock divider
	// =====================================================================
	localparam int OSR_HIGH = 384;
	localparam int OSR_LOW = 256;
	localparam int BIPHASE_PER_FRAME = 128; // two half cells for each of 64 bits
	localparam logic [1:0] DIV_HIGH = 2'(OSR_HIGH / BIPHASE_PER_FRAME);
	localparam logic [1:0] DIV_LOW = 2'(OSR_LOW / BIPHASE_PER_FRAME);

	// =====================================================================
	// serial clock timing made by the source end
	// =====================================================================
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int SCLK_PERIOD_MIN_NS = 80;
	localparam int SCLK_WIDTH_MIN_NS = 36;
	localparam int WIDTH_CYC = (SCLK_WIDTH_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int PERIOD_CYC = (SCLK_PERIOD_MIN_NS + 2 * CLOCK_PERIOD_NS - 1)
		/ (2 * CLOCK_PERIOD_NS);
	localparam int HALF_CYC = (WIDTH_CYC > PERIOD_CYC) ? WIDTH_CYC : PERIOD_CYC;
	localparam logic [3:0] SCLK_HALF_LAST = 4'(HALF_CYC - 1);

	// =====================================================================
	// helpers
	// =====================================================================
	// sample width in bits
	function automatic logic [5:0] width_bits(input stsi_width_e w);
		case (w)
			STSI_W16: width_bits = BITS_16;
			STSI_W18: width_bits = BITS_18;
			STSI_W20: width_bits = BITS_20;
			default: width_bits = BITS_24;
		endcase
	endfunction

	// slot position of the msb, counted from the select transition
	function automatic logic [5:0] msb_pos(input stsi_format_e f, input stsi_width_e w);
		case (f)
			STSI_FMT_LJ: msb_pos = LJ_DELAY;
			STSI_FMT_RJ: begin
				case (w)
					STSI_W16: msb_pos = RJ_DELAY_16;
					STSI_W18: msb_pos = RJ_DELAY_18;
					STSI_W20: msb_pos = RJ_DELAY_20;
					default: msb_pos = RJ_DELAY_24;
				endcase
			end
			default: msb_pos = I2S_DELAY;
		endcase
	endfunction

	// channel select level that marks the left slot
	function automatic logic left_level(input stsi_format_e f);
		case (f)
			STSI_FMT_LJ: left_level = 1'b1;
			STSI_FMT_RJ: left_level = 1'b1;
			default: left_level = 1'b0;
		endcase
	endfunction

endpackage

// [stsi_if.sv]
// three-wire serial audio link between a source and the transmitter input stage
`timescale 1ns/1ps
interface stsi_if;
	logic sclk; // serial bit clock
	logic lrclk; // channel select clock
	logic sdata; // serial data, msb first

	modport source (
		output sclk,
		output lrclk,
		output sdata
	);

	modport device (
		input sclk,
		input lrclk,
		input sdata
	);
endinterface

// [stsi_source.sv]
// source end: serialises stereo words onto the three-wire link
`timescale 1ns/1ps
module stsi_source (
	input wire logic clock_i,
	input wire logic arst_n_i,
	stsi_if.source link,
	input wire logic [1:0] format_i,
	input wire logic [1:0] width_i,
	input wire logic [23:0] left_i,
	input wire logic [23:0] right_i,
	output logic taken_o
);

	// =====================================================================
	// state
	// =====================================================================
	logic [3:0] half_cnt, next_half_cnt;
	logic [5:0] pos, next_pos;
	logic sclk, next_sclk;
	logic lrclk, next_lrclk;
	logic sdata, next_sdata;
	logic [23:0] held_left, next_held_left;
	logic [23:0] held_right, next_held_right;
	logic next_taken;

	// =====================================================================
	// clock divider and serialiser
	// =====================================================================
	// data and select change with the falling edge so they stand at the rising one
	always_comb begin
		logic [23:0] word;
		logic [5:0] sp;
		logic [5:0] start;
		logic [5:0] idx;
		stsi_pkg::stsi_format_e fmt;
		stsi_pkg::stsi_width_e wid;
		word = '0;
		sp = '0;
		idx = '0;
		fmt = stsi_pkg::stsi_format_e'(format_i);
		wid = stsi_pkg::stsi_width_e'(width_i);
		start = stsi_pkg::msb_pos(fmt, wid);
		next_half_cnt = half_cnt + 4'h1;
		next_pos = pos;
		next_sclk = sclk;
		next_lrclk = lrclk;
		next_sdata = sdata;
		next_held_left = held_left;
		next_held_right = held_right;
		next_taken = 1'b0;
		if (half_cnt == stsi_pkg::SCLK_HALF_LAST) begin
			next_half_cnt = '0;
			next_sclk = ~sclk;
			if (sclk) begin
				next_pos = pos + 6'h01;
				if (next_pos == '0) begin
					next_held_left = left_i;
					next_held_right = right_i;
					next_taken = 1'b1;
				end
				sp = next_pos & (stsi_pkg::SLOT_CLOCKS - 6'h01);
				word = (next_pos >= stsi_pkg::SLOT_CLOCKS) ? next_held_right : next_held_left;
				// left slot first, level per framing
				next_lrclk = (next_pos >= stsi_pkg::SLOT_CLOCKS) ?
					~stsi_pkg::left_level(fmt) : stsi_pkg::left_level(fmt);
				next_sdata = 1'b0;
				if (sp >= start && sp < start + stsi_pkg::width_bits(wid)) begin
					idx = sp - start;
					next_sdata = word[stsi_pkg::WORD_MSB - idx[4:0]];
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			half_cnt <= '0;
			pos <= stsi_pkg::FRAME_LAST;
			sclk <= 1'b0;
			lrclk <= 1'b0;
			sdata <= 1'b0;
			held_left <= '0;
			held_right <= '0;
			taken_o <= 1'b0;
		end else begin
			half_cnt <= next_half_cnt;
			pos <= next_pos;
			sclk <= next_sclk;
			lrclk <= next_lrclk;
			sdata <= next_sdata;
			held_left <= next_held_left;
			held_right <= next_held_right;
			taken_o <= next_taken;
		end
	end

	assign link.sclk = sclk;
	assign link.lrclk = lrclk;
	assign link.sdata = sdata;

endmodule // stsi_source

// [stsi_asserts.sv]
// concurrent checks on the serial audio link and the device outputs
`timescale 1ns/1ps
module stsi_asserts (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic sclk,
	input wire logic lrclk,
	input wire logic sdata,
	input wire logic [1:0] format_i,
	input wire logic [1:0] width_i,
	input wire logic [23:0] word_o,
	input wire logic word_left_o,
	input wire logic word_valid_o,
	input wire logic biphase_tick_o,
	input wire logic biphase_clk_o
);
	// ============================================================
	// slot position tracking
	// ============================================================
	logic sclk_q, lr_q, go, tag_lr, rise, hit, left_lvl;
	logic next_lr_q, next_go, next_tag;
	logic [5:0] pos, next_pos, bits, msb, last;
	logic [23:0] low_mask;
	// last bit position of a sample, from framing and width
	always_comb begin
		case (width_i)
			2'h0: bits = 6'h10;
			2'h1: bits = 6'h12;
			2'h2: bits = 6'h14;
			default: bits = 6'h18;
		endcase
		case (format_i)
			2'h1: msb = 6'h00;
			2'h3: msb = 6'h20 - bits;
			default: msb = 6'h01;
		endcase
		last = msb + bits - 6'h01;
		low_mask = 24'hffffff >> bits;
		left_lvl = (format_i == 2'h1) || (format_i == 2'h3);
	end
	assign rise = sclk && !sclk_q;
	assign hit = rise && go && (lrclk == lr_q) && (pos == last - 6'h01);
	// position restarts at each select change seen on a rising serial clock
	always_comb begin
		next_lr_q = lr_q;
		next_pos = pos;
		next_go = go;
		next_tag = hit ? lrclk : tag_lr;
		if (rise) begin
			next_lr_q = lrclk;
			if (lrclk != lr_q) begin
				next_pos = 6'h00;
				next_go = 1'b1;
			end else if (pos != 6'h3f) begin
				next_pos = pos + 6'h01;
			end
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_q <= 1'b0;
			lr_q <= 1'b0;
			pos <= 6'h3f;
			go <= 1'b0;
			tag_lr <= 1'b0;
		end else begin
			sclk_q <= sclk;
			lr_q <= next_lr_q;
			pos <= next_pos;
			go <= next_go;
			tag_lr <= next_tag;
		end
	end
	// ============================================================
	// assertions
	// ============================================================
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_last_bit;
		hit;
	endsequence
	sequence s_word_out;
		##2 word_valid_o;
	endsequence
	a_word_on_last: assert property (s_last_bit |-> s_word_out)
		else $error("word not emitted two cycles after last bit");
	a_no_stray_word: assert property (word_valid_o |-> $past(hit, 2))
		else $error("word emitted without a last bit");
	a_word_tag: assert property (word_valid_o |-> word_left_o == (tag_lr == left_lvl))
		else $error("channel tag wrong");
	a_word_masked: assert property (word_valid_o |-> (word_o & low_mask) == 24'h0)
		else $error("bits below sample width not zero");
	a_word_held: assert property (!word_valid_o |-> $stable(word_o) && $stable(word_left_o))
		else $error("word changed without valid");
	a_link_on_fall: assert property ($changed(lrclk) || $changed(sdata) |-> $fell(sclk))
		else $error("select or data moved off the falling serial clock");
	a_sclk_half: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("serial clock high time wrong");
	a_tick_toggle: assert property ($changed(biphase_clk_o) == biphase_tick_o)
		else $error("biphase clock not toggled by tick");
	a_tick_gap: assert property (biphase_tick_o |=> !biphase_tick_o [*5])
		else $error("biphase ticks too close");
endmodule // stsi_asserts

// [tb.sv]
// self-checking bench: source and device joined over the serial audio link
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb;
	logic clock_i, arst_n_i, ratio, osc, taken, word_left, word_valid, tick, bclk;
	logic sclk_q, lr_q, osc_q, mon_on;
	logic [1:0] fmt, wid;
	logic [23:0] left_v, right_v, word, cap;
	int bad_count, total_checks, cyc, pos, idx, osc_n, bp_seen;
	logic [1:0] fmts [3] = '{2'h0, 2'h1, 2'h3};
	stsi_if link();
	stsi_source i_stsi_source (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link),
		.format_i(fmt), .width_i(wid), .left_i(left_v), .right_i(right_v), .taken_o(taken));
	stsi_device i_stsi_device (.clock_i(clock_i), .arst_n_i(arst_n_i), .link(link),
		.format_i(fmt), .width_i(wid), .ratio_256_i(ratio), .oversampling_clock_i(osc),
		.word_o(word), .word_left_o(word_left), .word_valid_o(word_valid),
		.biphase_tick_o(tick), .biphase_clk_o(bclk));
	stsi_asserts i_stsi_asserts (.clock_i(clock_i), .arst_n_i(arst_n_i), .sclk(link.sclk),
		.lrclk(link.lrclk), .sdata(link.sdata), .format_i(fmt), .width_i(wid),
		.word_o(word), .word_left_o(word_left), .word_valid_o(word_valid),
		.biphase_tick_o(tick), .biphase_clk_o(bclk));
	// ============================================================
	// expectations
	// ============================================================
	function automatic int bits_of(input logic [1:0] w);
		return (w == 2'h3) ? 24 : 16 + 2 * w;
	endfunction
	function automatic int msb_of(input logic [1:0] f, input logic [1:0] w);
		return (f == 2'h1) ? 0 : (f == 2'h3) ? 32 - bits_of(w) : 1;
	endfunction
	function automatic logic lvl_of(input logic [1:0] f);
		return (f == 2'h1) || (f == 2'h3);
	endfunction
	function automatic logic [23:0] masked(input logic [23:0] v, input logic [1:0] w);
		return v & ~(24'hffffff >> bits_of(w));
	endfunction
	// ============================================================
	// clocks, timeout and verdict
	// ============================================================
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	initial begin
		osc = 1'b0;
		#3.3;
		forever #87 osc = ~osc;
	end
	task automatic conclude();
		if (bad_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			conclude();
		end
	end
	// ============================================================
	// wire monitor and biphase rate monitor
	// ============================================================
	always @(posedge clock_i) begin
		sclk_q <= link.sclk;
		osc_q <= osc;
		if (link.sclk && !sclk_q) begin
			lr_q <= link.lrclk;
			if (link.lrclk !== lr_q) begin
				if (mon_on) `CHK("slot length", 31, pos)
				pos = 0;
			end else if (pos < 63) pos = pos + 1;
			idx = pos - msb_of(fmt, wid);
			if (idx == 0) cap = 24'h0;
			if (idx >= 0 && idx < bits_of(wid)) cap[23 - idx] = link.sdata;
			if (mon_on && idx == bits_of(wid) - 1)
				`CHK("wire sample", masked(link.lrclk == lvl_of(fmt) ? left_v : right_v, wid), cap)
		end
		if (tick === 1'b1) begin
			if (bp_seen > 1) `CHK("osc per tick", ratio ? 2 : 3, osc_n)
			bp_seen = bp_seen + 1;
			osc_n = 0;
		end
		if (osc && !osc_q) osc_n = osc_n + 1;
	end
	// ============================================================
	// stimulus
	// ============================================================
	task automatic wait_on(input bit on_valid);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge clock_i);
			#1;
			if ((on_valid ? word_valid : taken) === 1'b1) break;
		end
		if (n == 400) `CHK("strobe wait", 1'b1, 1'b0)
	endtask
	task automatic run_case(input logic [1:0] f, input logic [1:0] w, input logic [23:0] l,
		input logic [23:0] r);
		logic prev;
		wait_on(0);
		repeat (2) @(posedge clock_i);
		#2;
		mon_on = 1'b0;
		bp_seen = 0;
		fmt = f;
		wid = w;
		left_v = l;
		right_v = r;
		ratio = 1'($urandom % 2);
		wait_on(0);
		wait_on(0);
		`CHK("left level", lvl_of(f), link.lrclk)
		mon_on = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wait_on(1);
			`CHK("word", masked(word_left ? l : r, w), word)
			if (k > 0) `CHK("tag order", ~prev, word_left)
			prev = word_left;
		end
	endtask
	initial begin
		void'($urandom(32'h09ad));
		{arst_n_i, ratio, fmt, wid, left_v, right_v, mon_on} = '0;
		{sclk_q, lr_q, osc_q, cap, cyc, idx, osc_n, bp_seen} = '0;
		pos = 63;
		repeat (8) @(posedge clock_i);
		#2;
		arst_n_i = 1'b1;
		wait_on(0);
		`CHK("default left level", 1'b0, link.lrclk)
		run_case(2'h0, 2'h3, 24'hffffff, 24'h000001);
		run_case(2'h3, 2'h0, 24'h800100, 24'h7fffff);
		run_case(2'h2, 2'h1, 24'h5a5a40, 24'ha5a5c0);
		for (int i = 0; i < 3; i++)
			for (int j = 0; j < 4; j++)
				run_case(fmts[i], 2'(j), 24'($urandom), 24'($urandom));
		conclude();
	end
endmodule // tb
